/* File: logic/dtc_timer_counter.sv */
// Dual timer/counter with four modes and external interrupt edge flags
// How it works
// - Timer function advances once per machine cycle of six CPU clocks.
// - Counter samples count pin once per machine cycle at sample phase.
// - Counted edge shows at update phase of the following machine cycle.
// - Edge needs two samples, so at most one count per 24 oscillator periods.
// - Source select bit: zero picks machine cycles, one picks count pin.
// - Mode 0 is 13 bits: high byte plus five prescaler bits of low byte.
// - Overflow flag set on rollover, cleared when interrupt is taken.
// - Counting only with run bit set and gate off or interrupt pin high; split-mode high byte ignores the gate.
// - Setting the run bit leaves the count unchanged.
// - Mode 1 cascades both bytes into a 16-bit counter.
// - Mode 2 counts low byte, reloads it from high byte on overflow.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Timer 0 mode 3: low byte uses timer 0, high byte uses timer 1 controls.
// - Timer 1 stops in its mode 3, resumes outside it; its overflow still pulses while timer 0 is in mode 3.
// - Edge flags set on interrupt pin edge, cleared when interrupt processed.
// - Type bit picks falling edge or low level triggering.
// - Run bits are software read/write, timer on when set.
`timescale 1ns/10ps
`default_nettype none

module dtc_timer_counter (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic [2:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       count_pin_zero_i,
	input  wire logic       count_pin_one_i,
	input  wire logic       ext_interrupt_zero_pin_i,
	input  wire logic       ext_interrupt_one_pin_i,
	input  wire logic       int_ack_timer0_i,
	input  wire logic       int_ack_timer1_i,
	input  wire logic       int_ack_ext0_i,
	input  wire logic       int_ack_ext1_i,
	output logic            ext_int_zero_req_o,
	output logic            ext_int_one_req_o,
	output logic            timer1_overflow_pulse_o,
	output logic            mc_tick_o
);
	import dtc_pkg::*;

	// Machine-cycle phase counter width
	localparam int PH_W = 3;
	localparam logic [PH_W-1:0] PH_LAST   = PH_W'(DTC_MC_CYCLES - 1);
	localparam logic [PH_W-1:0] PH_SAMPLE = PH_W'(DTC_SAMPLE_PHASE);
	localparam logic [PH_W-1:0] PH_UPDATE = PH_W'(DTC_UPDATE_PHASE);

	initial begin
		if (DTC_MC_CYCLES < 2 || DTC_MC_CYCLES > (1 << PH_W))
			$error("machine cycle length not served by phase counter");
		if (DTC_SAMPLE_PHASE >= DTC_MC_CYCLES || DTC_UPDATE_PHASE >= DTC_MC_CYCLES)
			$error("phase slot outside machine cycle");
	end

	typedef struct packed {
		logic [PH_W-1:0] phase;
		logic [7:0]      ctrl;
		logic [7:0]      mode;
		logic [7:0]      t0_lo;
		logic [7:0]      t0_hi;
		logic [7:0]      t1_lo;
		logic [7:0]      t1_hi;
		logic [1:0]      cnt_smp;   // last count pin sample per timer
		logic [1:0]      cnt_pend;  // detected edge awaiting update phase
		logic [1:0]      int_prev;  // previous interrupt pin level
		logic [7:0]      rdata;
		logic            eint0;
		logic            eint1;
		logic            t1_ovf;
		logic            tick;
	} dtc_state_s;

	dtc_state_s st_reg;
	dtc_state_s st_next;

	// Two-flop synchronisers for all pin inputs
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_meta_reg <= 4'h0;
			pin_sync_reg <= 4'h0;
		end else begin
			pin_meta_reg <= {ext_interrupt_one_pin_i, ext_interrupt_zero_pin_i,
				count_pin_one_i, count_pin_zero_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	logic [1:0] cnt_pin;
	logic [1:0] int_pin;
	assign cnt_pin = pin_sync_reg[1:0];
	assign int_pin = pin_sync_reg[3:2];

	// Per-timer decoded fields
	logic [3:0] nib0;
	logic [3:0] nib1;
	logic [1:0] md0;
	logic [1:0] md1;
	assign nib0 = st_reg.mode[DTC_MODE_GATE:DTC_MODE_M0];
	assign nib1 = st_reg.mode[DTC_T1_NIB+DTC_MODE_GATE:DTC_T1_NIB+DTC_MODE_M0];
	assign md0  = nib0[DTC_MODE_M1:DTC_MODE_M0];
	assign md1  = nib1[DTC_MODE_M1:DTC_MODE_M0];

	// Advance one 8-bit counter stage: returns carry in bit 8
	function automatic logic [8:0] inc8(input logic [7:0] v, input logic en);
		inc8 = {1'b0, v} + {8'h00, en};
	endfunction

	// Next state: register port, phase, counting, flags
	always_comb begin
		logic       upd;
		logic       smp;
		logic [1:0] run;
		logic [1:0] src_ev;
		logic       t0_ev;
		logic       t1_ev;
		logic       th0_ev;
		logic [8:0] lo_s;
		logic [8:0] hi_s;
		logic       ovf0;
		logic       ovf1;
		logic       ovf_th0;
		logic       fall0;
		logic       fall1;
		upd    = 1'b0;
		smp    = 1'b0;
		run    = 2'b00;
		src_ev = 2'b00;
		t0_ev  = 1'b0;
		t1_ev  = 1'b0;
		th0_ev = 1'b0;
		lo_s   = 9'h000;
		hi_s   = 9'h000;
		ovf0   = 1'b0;
		ovf1   = 1'b0;
		ovf_th0 = 1'b0;
		fall0  = 1'b0;
		fall1  = 1'b0;
		st_next = st_reg;
		st_next.t1_ovf = 1'b0;

		// Machine cycle of six CPU clocks
		st_next.phase = (st_reg.phase == PH_LAST) ? '0 : st_reg.phase + 1'b1;
		st_next.tick  = (st_reg.phase == PH_LAST);
		upd = (st_reg.phase == PH_UPDATE);
		smp = (st_reg.phase == PH_SAMPLE);

		// Sample count pins; a high then low sample arms a count
		if (smp) begin
			st_next.cnt_smp = cnt_pin;
			st_next.cnt_pend = st_reg.cnt_pend | (st_reg.cnt_smp & ~cnt_pin);
		end

		// Gate: run bit and (gate off or interrupt pin high)
		run[0] = st_reg.ctrl[DTC_CTRL_TR0] &
			(~nib0[DTC_MODE_GATE] | int_pin[0]);
		run[1] = st_reg.ctrl[DTC_CTRL_TR1] &
			(~nib1[DTC_MODE_GATE] | int_pin[1]);

		// Source: machine cycle or pending pin edge, applied at update phase
		src_ev[0] = nib0[DTC_MODE_CT] ? st_reg.cnt_pend[0] : 1'b1;
		src_ev[1] = nib1[DTC_MODE_CT] ? st_reg.cnt_pend[1] : 1'b1;
		if (upd) begin
			st_next.cnt_pend = 2'b00;
			if (smp)
				st_next.cnt_pend = st_reg.cnt_smp & ~cnt_pin;
		end
		t0_ev  = upd & run[0] & src_ev[0];
		t1_ev  = upd & run[1] & src_ev[1] & (md1 != DTC_MODE_SPLIT);
		// Split-mode high byte counts machine cycles under timer 1 run bit
		th0_ev = upd & st_reg.ctrl[DTC_CTRL_TR1] & (md0 == DTC_MODE_SPLIT);

		// Timer 0 counting
		unique case (md0)
			DTC_MODE_13BIT: begin
				lo_s = {4'h0, st_reg.t0_lo[DTC_PRESC_W-1:0]} + {8'h00, t0_ev};
				st_next.t0_lo = {st_reg.t0_lo[7:DTC_PRESC_W], lo_s[DTC_PRESC_W-1:0]};
				hi_s = inc8(st_reg.t0_hi, t0_ev & (st_reg.t0_lo[DTC_PRESC_W-1:0] == DTC_PRESC_MAX));
				st_next.t0_hi = hi_s[7:0];
				ovf0 = hi_s[8];
			end
			DTC_MODE_16BIT: begin
				lo_s = inc8(st_reg.t0_lo, t0_ev);
				hi_s = inc8(st_reg.t0_hi, lo_s[8]);
				st_next.t0_lo = lo_s[7:0];
				st_next.t0_hi = hi_s[7:0];
				ovf0 = hi_s[8];
			end
			DTC_MODE_RELOAD: begin
				lo_s = inc8(st_reg.t0_lo, t0_ev);
				st_next.t0_lo = lo_s[8] ? st_reg.t0_hi : lo_s[7:0];
				ovf0 = lo_s[8];
			end
			DTC_MODE_SPLIT: begin
				lo_s = inc8(st_reg.t0_lo, t0_ev);
				hi_s = inc8(st_reg.t0_hi, th0_ev);
				st_next.t0_lo = lo_s[7:0];
				st_next.t0_hi = hi_s[7:0];
				ovf0 = lo_s[8];
				ovf_th0 = hi_s[8];
			end
		endcase

		// Timer 1 counting; mode 3 leaves the count untouched
		unique case (md1)
			DTC_MODE_13BIT: begin
				lo_s = {4'h0, st_reg.t1_lo[DTC_PRESC_W-1:0]} + {8'h00, t1_ev};
				st_next.t1_lo = {st_reg.t1_lo[7:DTC_PRESC_W], lo_s[DTC_PRESC_W-1:0]};
				hi_s = inc8(st_reg.t1_hi, t1_ev & (st_reg.t1_lo[DTC_PRESC_W-1:0] == DTC_PRESC_MAX));
				st_next.t1_hi = hi_s[7:0];
				ovf1 = hi_s[8];
			end
			DTC_MODE_16BIT: begin
				lo_s = inc8(st_reg.t1_lo, t1_ev);
				hi_s = inc8(st_reg.t1_hi, lo_s[8]);
				st_next.t1_lo = lo_s[7:0];
				st_next.t1_hi = hi_s[7:0];
				ovf1 = hi_s[8];
			end
			DTC_MODE_RELOAD: begin
				lo_s = inc8(st_reg.t1_lo, t1_ev);
				st_next.t1_lo = lo_s[8] ? st_reg.t1_hi : lo_s[7:0];
				ovf1 = lo_s[8];
			end
			DTC_MODE_SPLIT: begin
				ovf1 = 1'b0;
			end
		endcase

		// Timer 1 overflow pulse for baud use, even while its flag is borrowed
		st_next.t1_ovf = ovf1;

		// External interrupt: type one falls on edge, zero on low level
		fall0 = st_reg.int_prev[0] & ~int_pin[0];
		fall1 = st_reg.int_prev[1] & ~int_pin[1];
		st_next.int_prev = int_pin;

		// Register writes; hardware sets below take priority over them
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				DTC_ADDR_CTRL:  st_next.ctrl  = reg_wdata_i;
				DTC_ADDR_MODE:  st_next.mode  = reg_wdata_i;
				DTC_ADDR_T0_LO: st_next.t0_lo = reg_wdata_i;
				DTC_ADDR_T0_HI: st_next.t0_hi = reg_wdata_i;
				DTC_ADDR_T1_LO: st_next.t1_lo = reg_wdata_i;
				DTC_ADDR_T1_HI: st_next.t1_hi = reg_wdata_i;
				default: begin
					if (reg_addr_i == DTC_ADDR_ACK) begin
						if (reg_wdata_i[DTC_ACK_TF0]) st_next.ctrl[DTC_CTRL_TF0] = 1'b0;
						if (reg_wdata_i[DTC_ACK_TF1]) st_next.ctrl[DTC_CTRL_TF1] = 1'b0;
						if (reg_wdata_i[DTC_ACK_IE0]) st_next.ctrl[DTC_CTRL_IE0] = 1'b0;
						if (reg_wdata_i[DTC_ACK_IE1]) st_next.ctrl[DTC_CTRL_IE1] = 1'b0;
					end
				end
			endcase
		end

		// Vectoring clears the flags; a set in the same cycle wins
		if (int_ack_timer0_i) st_next.ctrl[DTC_CTRL_TF0] = 1'b0;
		if (int_ack_timer1_i) st_next.ctrl[DTC_CTRL_TF1] = 1'b0;
		if (int_ack_ext0_i)   st_next.ctrl[DTC_CTRL_IE0] = 1'b0;
		if (int_ack_ext1_i)   st_next.ctrl[DTC_CTRL_IE1] = 1'b0;
		if (ovf0) st_next.ctrl[DTC_CTRL_TF0] = 1'b1;
		if (ovf1 & (md0 != DTC_MODE_SPLIT)) st_next.ctrl[DTC_CTRL_TF1] = 1'b1;
		if (ovf_th0) st_next.ctrl[DTC_CTRL_TF1] = 1'b1;
		if (fall0) st_next.ctrl[DTC_CTRL_IE0] = 1'b1;
		if (fall1) st_next.ctrl[DTC_CTRL_IE1] = 1'b1;

		// Request: edge flag when type is one, pin low level when zero
		st_next.eint0 = st_reg.ctrl[DTC_CTRL_IT0] ? st_next.ctrl[DTC_CTRL_IE0] : ~int_pin[0];
		st_next.eint1 = st_reg.ctrl[DTC_CTRL_IT1] ? st_next.ctrl[DTC_CTRL_IE1] : ~int_pin[1];

		// Read data one cycle after the strobe; unmapped reads zero
		st_next.rdata = DTC_RST_BYTE;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				DTC_ADDR_CTRL:  st_next.rdata = st_reg.ctrl;
				DTC_ADDR_MODE:  st_next.rdata = st_reg.mode;
				DTC_ADDR_T0_LO: st_next.rdata = st_reg.t0_lo;
				DTC_ADDR_T0_HI: st_next.rdata = st_reg.t0_hi;
				DTC_ADDR_T1_LO: st_next.rdata = st_reg.t1_lo;
				DTC_ADDR_T1_HI: st_next.rdata = st_reg.t1_hi;
				default:        st_next.rdata = DTC_RST_BYTE;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign reg_rdata_o             = st_reg.rdata;
	assign ext_int_zero_req_o      = st_reg.eint0;
	assign ext_int_one_req_o       = st_reg.eint1;
	assign timer1_overflow_pulse_o = st_reg.t1_ovf;
	assign mc_tick_o               = st_reg.tick;

	// Counts move only at the update phase slot
	property p_update_only;
		@(posedge sys_clk_i) disable iff (reset_i)
		(st_reg.phase != PH_LAST) && (st_reg.phase != PH_UPDATE) && !reg_wr_i
		|=> $stable(st_reg.t1_hi) && $stable(st_reg.t0_hi);
	endproperty
	a_update_only: assert property (p_update_only) else $error("count moved off phase");

	// Machine tick every six clocks
	property p_tick_period;
		@(posedge sys_clk_i) disable iff (reset_i)
		mc_tick_o |-> ##6 mc_tick_o;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

	// Stopped timer 1 holds
	property p_t1_hold;
		@(posedge sys_clk_i) disable iff (reset_i)
		(!st_reg.ctrl[DTC_CTRL_TR1] || md1 == DTC_MODE_SPLIT) && !reg_wr_i
		|=> $stable(st_reg.t1_lo);
	endproperty
	a_t1_hold: assert property (p_t1_hold) else $error("timer 1 moved while stopped");

	// Timer 0 overflow sets its flag next cycle
	property p_tf0_set;
		@(posedge sys_clk_i) disable iff (reset_i)
		(st_reg.phase == PH_UPDATE) && md0 == DTC_MODE_16BIT && st_reg.t0_lo == DTC_BYTE_MAX
		&& st_reg.t0_hi == DTC_BYTE_MAX && st_reg.ctrl[DTC_CTRL_TR0]
		&& !nib0[DTC_MODE_GATE] && !nib0[DTC_MODE_CT] && !reg_wr_i
		|=> st_reg.ctrl[DTC_CTRL_TF0] && st_reg.t0_hi == 8'h00;
	endproperty
	a_tf0_set: assert property (p_tf0_set) else $error("timer 0 overflow flag missed");

	// Mode 2 reload keeps high byte
	property p_reload;
		@(posedge sys_clk_i) disable iff (reset_i)
		(st_reg.phase == PH_UPDATE) && md0 == DTC_MODE_RELOAD && st_reg.t0_lo == DTC_BYTE_MAX
		&& st_reg.ctrl[DTC_CTRL_TR0] && !nib0[DTC_MODE_GATE] && !nib0[DTC_MODE_CT] && !reg_wr_i
		|=> st_reg.t0_lo == $past(st_reg.t0_hi) && $stable(st_reg.t0_hi);
	endproperty
	a_reload: assert property (p_reload) else $error("reload wrong");

	// Gated timer 0 with pin low does not count
	property p_gate;
		@(posedge sys_clk_i) disable iff (reset_i)
		nib0[DTC_MODE_GATE] && !int_pin[0] && md0 == DTC_MODE_16BIT && !reg_wr_i
		|=> $stable(st_reg.t0_lo);
	endproperty
	a_gate: assert property (p_gate) else $error("gated timer counted");

	// Falling interrupt pin sets edge flag
	property p_edge_flag;
		@(posedge sys_clk_i) disable iff (reset_i)
		st_reg.int_prev[0] && !int_pin[0] |=> st_reg.ctrl[DTC_CTRL_IE0];
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("edge flag missed");

	// Acknowledge clears a flag when no overflow coincides
	property p_ack_clear;
		@(posedge sys_clk_i) disable iff (reset_i)
		int_ack_timer0_i && st_reg.phase != PH_UPDATE |=> !st_reg.ctrl[DTC_CTRL_TF0];
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");

endmodule : dtc_timer_counter

`default_nettype wire

/* File: inc/dtc_pkg.sv */
// Package for the dual timer/counter: register map, fields, timing constants
package dtc_pkg;

	// Register indices on the plain register port
	localparam logic [2:0] DTC_ADDR_CTRL  = 3'h0; // timer_run_control
	localparam logic [2:0] DTC_ADDR_MODE  = 3'h1; // timer_mode_config
	localparam logic [2:0] DTC_ADDR_T0_LO = 3'h2; // timer0_low_byte
	localparam logic [2:0] DTC_ADDR_T0_HI = 3'h3; // timer0_high_byte
	localparam logic [2:0] DTC_ADDR_T1_LO = 3'h4; // timer1_low_byte
	localparam logic [2:0] DTC_ADDR_T1_HI = 3'h5; // timer1_high_byte
	localparam logic [2:0] DTC_ADDR_ACK   = 3'h6; // interrupt acknowledge strobes

	// Control register bit positions
	localparam int DTC_CTRL_TF1 = 7;
	localparam int DTC_CTRL_TR1 = 6;
	localparam int DTC_CTRL_TF0 = 5;
	localparam int DTC_CTRL_TR0 = 4;
	localparam int DTC_CTRL_IE1 = 3;
	localparam int DTC_CTRL_IT1 = 2;
	localparam int DTC_CTRL_IE0 = 1;
	localparam int DTC_CTRL_IT0 = 0;

	// Mode register: per-timer nibble, timer 1 high
	localparam int DTC_MODE_GATE = 3;
	localparam int DTC_MODE_CT   = 2;
	localparam int DTC_MODE_M1   = 1;
	localparam int DTC_MODE_M0   = 0;
	localparam int DTC_T1_NIB    = 4;

	// Acknowledge register bits (write one to clear)
	localparam int DTC_ACK_TF0 = 0;
	localparam int DTC_ACK_TF1 = 1;
	localparam int DTC_ACK_IE0 = 2;
	localparam int DTC_ACK_IE1 = 3;

	// Reset values
	localparam logic [7:0] DTC_RST_BYTE = 8'h00;

	// Operating modes
	localparam logic [1:0] DTC_MODE_13BIT  = 2'h0;
	localparam logic [1:0] DTC_MODE_16BIT  = 2'h1;
	localparam logic [1:0] DTC_MODE_RELOAD = 2'h2;
	localparam logic [1:0] DTC_MODE_SPLIT  = 2'h3;

	// Mode 0 prescaler width
	localparam int         DTC_PRESC_W    = 5;
	localparam logic [4:0] DTC_PRESC_MAX  = 5'h1F;
	localparam logic [7:0] DTC_BYTE_MAX   = 8'hFF;

	// Timing: oscillator periods per machine cycle and clock rate
	localparam int DTC_SYS_PERIOD_NS = 10;
	localparam int DTC_OSC_PER_MC    = 12;
	localparam int DTC_CPU_PER_MC    = 6;
	// One machine cycle = six CPU clocks; CPU clock is sys_clk
	localparam int DTC_MC_CYCLES     = DTC_CPU_PER_MC;
	localparam int DTC_SAMPLE_PHASE  = 4; // sample_phase slot within the cycle
	localparam int DTC_UPDATE_PHASE  = 2; // update_phase slot within the cycle

endpackage : dtc_pkg

/* File: test/dtc_far_side_model.sv */
// Far-side model: count pins, interrupt pins and CPU acknowledge pulses
`timescale 1ns/10ps
`default_nettype none

module dtc_far_side_model (
	input  wire logic       sys_clk_i,
	output var  logic [1:0] count_pin_o,
	output var  logic [1:0] int_pin_o,
	output var  logic [3:0] ack_o
);
	// Pins idle high, no acknowledge pending
	initial begin
		count_pin_o = 2'h3;
		int_pin_o = 2'h3;
		ack_o = 4'h0;
	end

	// Falling edges; each level held at least one machine cycle
	task automatic pulse_count(input int p, input int n, input int hold);
		repeat (n) begin
			repeat (hold) @(posedge sys_clk_i);
			count_pin_o[p] <= 1'b0;
			repeat (hold) @(posedge sys_clk_i);
			count_pin_o[p] <= 1'b1;
		end
	endtask

	// Interrupt pin level, which is also the gate of its timer
	task automatic set_int(input int p, input logic lvl);
		@(posedge sys_clk_i);
		int_pin_o[p] <= lvl;
	endtask

	// Vector taken: 0 timer 0, 1 timer 1, 2 ext 0, 3 ext 1
	task automatic ack(input int k);
		@(posedge sys_clk_i);
		ack_o[k] <= 1'b1;
		@(posedge sys_clk_i);
		ack_o[k] <= 1'b0;
	endtask

endmodule // dtc_far_side_model
`default_nettype wire

/* File: test/dtc_timer_counter_tb.sv */
// Testbench for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none

module dtc_timer_counter_tb;
	import dtc_pkg::*;

	logic        sys_clk_i;
	logic        reset_i;
	logic [2:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_rdata_o;
	logic [1:0]  cnt_pin;
	logic [1:0]  int_pin;
	logic [3:0]  ack;
	logic [1:0]  req;
	logic        t1_pulse;
	logic        mc_tick_o;
	logic [7:0]  d;
	logic [15:0] v;
	logic [15:0] w;
	int          t;
	int          n;
	int          failures;
	int          checks;
	int          cycles;
	int          t1_pulses;
	int          seed;

	dtc_timer_counter dtc_timer_counter_i (
		.sys_clk_i               (sys_clk_i),
		.reset_i                 (reset_i),
		.reg_addr_i              (reg_addr_i),
		.reg_wdata_i             (reg_wdata_i),
		.reg_wr_i                (reg_wr_i),
		.reg_rd_i                (reg_rd_i),
		.reg_rdata_o             (reg_rdata_o),
		.count_pin_zero_i        (cnt_pin[0]),
		.count_pin_one_i         (cnt_pin[1]),
		.ext_interrupt_zero_pin_i(int_pin[0]),
		.ext_interrupt_one_pin_i (int_pin[1]),
		.int_ack_timer0_i        (ack[0]),
		.int_ack_timer1_i        (ack[1]),
		.int_ack_ext0_i          (ack[2]),
		.int_ack_ext1_i          (ack[3]),
		.ext_int_zero_req_o      (req[0]),
		.ext_int_one_req_o       (req[1]),
		.timer1_overflow_pulse_o (t1_pulse),
		.mc_tick_o               (mc_tick_o)
	);

	dtc_far_side_model dtc_far_side_model_i (
		.sys_clk_i  (sys_clk_i),
		.count_pin_o(cnt_pin),
		.int_pin_o  (int_pin),
		.ack_o      (ack)
	);

	// Free-running 100 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Hang guard and overflow pulse tally
	always @(posedge sys_clk_i) begin
		cycles++;
		if (t1_pulse === 1'b1) t1_pulses++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("Checks %0d, failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] dat);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= dat;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe; taken mid-cycle
	task automatic rd(input logic [2:0] a, output logic [7:0] dat);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		dat = reg_rdata_o;
		@(posedge sys_clk_i);
	endtask

	task automatic wr16(input int k, input logic [15:0] val);
		wr(k ? DTC_ADDR_T1_LO : DTC_ADDR_T0_LO, val[7:0]);
		wr(k ? DTC_ADDR_T1_HI : DTC_ADDR_T0_HI, val[15:8]);
	endtask

	task automatic rd16(input int k, output logic [15:0] val);
		rd(k ? DTC_ADDR_T1_LO : DTC_ADDR_T0_LO, val[7:0]);
		rd(k ? DTC_ADDR_T1_HI : DTC_ADDR_T0_HI, val[15:8]);
	endtask

	// Run bits high for exactly 6*m clock edges when no ack is taken, so exactly m updates
	task automatic run_for(input logic [7:0] on, input int m, input logic [7:0] fm,
		input bit fexp, input int ak);
		logic [7:0] c;
		wr(DTC_ADDR_CTRL, on);
		repeat (6 * m - 5) @(posedge sys_clk_i);
		rd(DTC_ADDR_CTRL, c);
		chk(16'(c & fm), fexp ? 16'(fm) : 16'h0000);
		if (ak >= 0) begin
			dtc_far_side_model_i.ack(ak);
			rd(DTC_ADDR_CTRL, c);
			chk(16'(c & fm), 16'h0000);
		end
		wr(DTC_ADDR_CTRL, 8'h00);
	endtask

	function automatic logic [15:0] next_count(input logic [15:0] val, input int m);
		return val + 16'(m);
	endfunction

	// Flag is visible at the read only if the wrap came a cycle early
	function automatic bit wraps(input logic [15:0] val, input int m);
		return (65536 - int'(val)) <= m - 1;
	endfunction

	// Main sequence
	initial begin
		seed = 96;
		reset_i = 1'b1;
		reg_addr_i = 3'h0;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		repeat (5) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		wr(3'h7, 8'hFF);
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), d);
			chk(16'(d), 16'h0000);
		end
		n = 0;
		repeat (60) begin
			@(posedge sys_clk_i);
			if (mc_tick_o === 1'b1) n++;
		end
		chk(16'(n), 16'h000A);
		// Random preloads in 16-bit mode on either timer
		repeat (8) begin
			t = $random(seed) & 1;
			n = 2 + ($random(seed) & 7);
			v = 16'($random(seed));
			if (65536 - int'(v) == n) v = v + 16'h0001;
			wr(DTC_ADDR_MODE, t ? 8'h10 : 8'h01);
			wr16(t, v);
			run_for(t ? 8'h40 : 8'h10, n, t ? 8'h80 : 8'h20, wraps(v, n), -1);
			rd16(t, w);
			chk(w, next_count(v, n));
		end
		// Wrap from all ones, then acknowledge clears the flag
		for (int k = 0; k < 2; k++) begin
			wr(DTC_ADDR_MODE, 8'h11);
			wr16(k, 16'hFFFF);
			run_for(k ? 8'h40 : 8'h10, 2, k ? 8'h80 : 8'h20, 1'b1, k);
		end
		wr(DTC_ADDR_MODE, 8'h00);
		wr16(0, 16'hFFFE);
		run_for(8'h10, 3, 8'h20, 1'b1, -1);
		rd16(0, w);
		chk(w, 16'h00E1);
		// Both timers in reload mode, both wrap once
		wr(DTC_ADDR_MODE, 8'h22);
		wr16(1, 16'hA5FE);
		wr16(0, 16'h33FE);
		t1_pulses = 0;
		run_for(8'h50, 4, 8'hA0, 1'b1, -1);
		rd16(1, w);
		chk(w, 16'hA5A7);
		rd16(0, w);
		chk(w, 16'h3335);
		chk(16'(t1_pulses), 16'h0001);
		wr(DTC_ADDR_MODE, 8'h30);
		wr16(1, 16'h1234);
		run_for(8'h40, 3, 8'h80, 1'b0, -1);
		rd16(1, w);
		chk(w, 16'h1234);
		wr(DTC_ADDR_MODE, 8'h33);
		wr16(0, 16'hFEFE);
		wr16(1, 16'h0077);
		run_for(8'h50, 4, 8'hA0, 1'b1, -1);
		rd16(0, w);
		chk(w, 16'h0202);
		rd16(1, w);
		chk(w, 16'h0077);
		// Gate low stops timer 0, gate high lets it run
		wr(DTC_ADDR_MODE, 8'h09);
		for (int g = 0; g < 2; g++) begin
			wr16(0, 16'h0000);
			dtc_far_side_model_i.set_int(0, 1'(g));
			repeat (6) @(posedge sys_clk_i);
			run_for(8'h10, 3, 8'h20, 1'b0, -1);
			rd16(0, w);
			chk(w, g ? 16'h0003 : 16'h0000);
		end
		// Pin edges at the fastest legal rate
		for (int k = 0; k < 2; k++) begin
			wr(DTC_ADDR_MODE, k ? 8'h50 : 8'h05);
			wr16(k, 16'h0000);
			wr(DTC_ADDR_CTRL, k ? 8'h40 : 8'h10);
			dtc_far_side_model_i.pulse_count(k, 5, 6);
			repeat (24) @(posedge sys_clk_i);
			wr(DTC_ADDR_CTRL, 8'h00);
			rd16(k, w);
			chk(w, 16'h0005);
		end
		// Level then edge triggering on both interrupt pins
		for (int k = 0; k < 2; k++) begin
			wr(DTC_ADDR_CTRL, 8'h00);
			dtc_far_side_model_i.set_int(k, 1'b0);
			repeat (6) @(posedge sys_clk_i);
			chk(16'(req[k]), 16'h0001);
			dtc_far_side_model_i.set_int(k, 1'b1);
			repeat (6) @(posedge sys_clk_i);
			chk(16'(req[k]), 16'h0000);
			dtc_far_side_model_i.ack(2 + k);
			wr(DTC_ADDR_CTRL, k ? 8'h04 : 8'h01);
			dtc_far_side_model_i.set_int(k, 1'b0);
			repeat (6) @(posedge sys_clk_i);
			rd(DTC_ADDR_CTRL, d);
			chk(16'(d), k ? 16'h000C : 16'h0003);
			dtc_far_side_model_i.set_int(k, 1'b1);
			repeat (6) @(posedge sys_clk_i);
			chk(16'(req[k]), 16'h0001);
			dtc_far_side_model_i.ack(2 + k);
			repeat (2) @(posedge sys_clk_i);
			chk(16'(req[k]), 16'h0000);
		end
		stop_test();
	end

endmodule // dtc_timer_counter_tb
`default_nettype wire
